// File: policy_pkg.sv
// Operation
// - Slot 5 takes new keys only by encrypted write under slot 6; clear writes refused.
// - Slot 5 holds two 128-bit keys and never returns them on read.
// - Permanent slot 5 refuses every encrypted write.
// - Slots 5 to 9 are refused as copy target of the mac check command.
// - Slot 6 takes clear writes while unlocked and is never read.
// - Any use of the slot 6 key needs a random nonce generated first.
// - Permanent slots 6, 8, 13, 15 refuse writes, reads unchanged.
// - Slot 7 is never read or written and never a mac key source.
// - Slot 8 allows clear reads and clear writes while unlocked.
// - Slot 9 holds four 128-bit keys, takes clear writes, never read.
// - Permanent slots 10 to 12 read in clear and refuse writes.
// - Lockable slots 10 to 12 also take writes until locked.
// - Slot 13 takes clear writes until locked and is always readable.
// - Slot 14 key verifies only while validated.
// - Slot 14 writes only while not validated, including from reset; always readable.
// - Slot 15 writable unless locked, always readable.
// - One-time zone is 64 bytes in two 32-byte blocks, never written.
// - One-time zone reads in 4-byte or 32-byte units at any time.
// - Sleep or power loss invalidates scratch memory; scratch never read.
// - Scratch key register is 64 bytes in halves, internal use only.
// - Digest buffer feeds signing; only the hash digest command writes into it, not hash finalize.
// - Alternate key buffer loads from nonce fixed value or key derivation.
// - Policy refusal answers status 0x0F in a four-byte group.
package policy_pkg;
	typedef enum logic [4:0] {
		OP_READ       = 5'b00000,
		OP_WRITE      = 5'b00001,
		OP_ENC_WRITE  = 5'b00010,
		OP_COPY       = 5'b00011,
		OP_MAC_KEY    = 5'b00100,
		OP_VERIFY     = 5'b00101,
		OP_LOCK       = 5'b00110,
		OP_VALIDATE   = 5'b00111,
		OP_INVALIDATE = 5'b01000,
		OP_NONCE_RAND = 5'b01001,
		OP_NONCE_ALT  = 5'b01010,
		OP_KDF        = 5'b01011,
		OP_SHA_INIT   = 5'b01100,
		OP_SHA_UPDATE = 5'b01101,
		OP_SHA_FINAL  = 5'b01110,
		OP_SHA_DIGEST = 5'b01111,
		OP_SIGN_DIG   = 5'b10000,
		OP_OTP_READ4  = 5'b10001,
		OP_OTP_READ32 = 5'b10010,
		OP_OTP_WRITE  = 5'b10011,
		OP_SCRATCH_RD = 5'b10100
	} op_e;
	typedef enum logic {
		SHA_IDLE   = 1'b0,
		SHA_ACTIVE = 1'b1
	} sha_e;
	typedef struct packed {
		logic       valid;
		op_e        op;
		logic [3:0] slot;
		logic [3:0] addr;
	} req_s;
	typedef struct packed {
		logic       valid;
		logic       allow;
		logic [7:0] status;
		logic [7:0] count;
	} resp_s;
	localparam logic [7:0]  ST_OK       = 8'h00;
	localparam logic [7:0]  ST_EXEC_ERR = 8'h0F;
	localparam logic [7:0]  GROUP_LEN   = 8'h04;
	localparam logic [3:0]  SLOT_SECRET = 4'h5;
	localparam logic [3:0]  SLOT_IOKEY  = 4'h6;
	localparam logic [3:0]  SLOT_BOOTDG = 4'h7;
	localparam logic [3:0]  SLOT_DATA   = 4'h8;
	localparam logic [3:0]  SLOT_AES    = 4'h9;
	localparam logic [3:0]  SLOT_CERT   = 4'hA;
	localparam logic [3:0]  SLOT_SIGNER = 4'hB;
	localparam logic [3:0]  SLOT_SCERT  = 4'hC;
	localparam logic [3:0]  SLOT_PARENT = 4'hD;
	localparam logic [3:0]  SLOT_VALID  = 4'hE;
	localparam logic [3:0]  SLOT_BOOTPK = 4'hF;
	localparam int          OTP_BYTES   = 64;
	localparam int          OTP_BLOCK   = 32;
	localparam int          OTP_WORD    = 4;
	localparam int          OTP_ADDR_W  = 4;
	localparam logic [15:0] LOCK_RST    = 16'h0000;
	localparam logic        VALID_RST   = 1'b0;
endpackage

// File: otp_store.sv
`timescale 1ns/100ps
`default_nettype none
module otp_store #(
	parameter logic [511:0] OTP_INIT = 512'h0
) (
	input  wire logic                                 clk,
	input  wire logic                                 reset,
	input  wire logic                                 rd,
	input  wire logic                                 wide,
	input  wire logic [policy_pkg::OTP_ADDR_W-1:0]    addr,
	output logic      [policy_pkg::OTP_BLOCK*8-1:0]   data
);
	typedef struct packed {
		logic [policy_pkg::OTP_BLOCK*8-1:0] data;
	} otp_state_s;

	otp_state_s st_q;
	otp_state_s st_d;
	logic [7:0] mem [policy_pkg::OTP_BYTES];

	////////////////////////////////////////////////////////////////////////
	// Contents are fixed at build time; no write path exists at all.
	always_comb begin
		for (int i = 0; i < policy_pkg::OTP_BYTES; i++) begin
			mem[i] = OTP_INIT[i*8 +: 8];
		end
	end

	// A wide read returns the block that bit 3 selects; a narrow one returns
	// one word in the low bytes and zeros above.
	always_comb begin
		logic [5:0] base;
		base = 6'h00;
		st_d = st_q;
		if (rd) begin
			st_d.data = '0;
			if (wide) begin
				base = {addr[3], 5'h00};
				for (int i = 0; i < policy_pkg::OTP_BLOCK; i++) begin
					st_d.data[i*8 +: 8] = mem[6'(base + 6'(i))];
				end
			end else begin
				base = {addr, 2'b00};
				for (int i = 0; i < policy_pkg::OTP_WORD; i++) begin
					st_d.data[i*8 +: 8] = mem[6'(base + 6'(i))];
				end
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign data = st_q.data;
endmodule
`default_nettype wire

// File: slot_access_policy_checker.sv
`timescale 1ns/100ps
`default_nettype none
module slot_access_policy_checker #(
	// Arbitrary neutral identity contents for the one-time zone.
	parameter logic [511:0] OTP_INIT = 512'h0
) (
	input  wire logic                                clk,
	input  wire logic                                reset,
	input  wire policy_pkg::req_s                    req,
	input  wire logic [15:0]                         perm_opt,
	input  wire logic                                sleep,
	output var  policy_pkg::resp_s                   resp,
	output logic      [policy_pkg::OTP_BLOCK*8-1:0]  otp_data,
	output logic      [15:0]                         locked,
	output logic                                     validated,
	output logic                                     nonce_ok
);
	typedef struct packed {
		logic [15:0]       locked;
		logic              validated;
		logic              nonce;
		logic              tk_valid;
		logic              digest;
		logic              altkey;
		policy_pkg::sha_e  sha;
		policy_pkg::resp_s resp;
	} state_s;

	state_s st_q;
	state_s st_d;
	logic   ok;
	logic   wr_open;

	////////////////////////////////////////////////////////////////////////
	// Slots whose contents may leave the device in clear.
	function automatic logic clear_readable(input logic [3:0] s);
		case (s)
			policy_pkg::SLOT_DATA,
			policy_pkg::SLOT_CERT,
			policy_pkg::SLOT_SIGNER,
			policy_pkg::SLOT_SCERT,
			policy_pkg::SLOT_PARENT,
			policy_pkg::SLOT_VALID,
			policy_pkg::SLOT_BOOTPK: clear_readable = 1'b1;
			default:                 clear_readable = 1'b0;
		endcase
	endfunction

	// Slots that carry a lock option; slots 7, 9 and 14 have none.
	function automatic logic lockable(input logic [3:0] s);
		case (s)
			policy_pkg::SLOT_SECRET,
			policy_pkg::SLOT_IOKEY,
			policy_pkg::SLOT_DATA,
			policy_pkg::SLOT_CERT,
			policy_pkg::SLOT_SIGNER,
			policy_pkg::SLOT_SCERT,
			policy_pkg::SLOT_PARENT,
			policy_pkg::SLOT_BOOTPK: lockable = 1'b1;
			default:                 lockable = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// A slot is open to writes while its option is lockable and not locked.
	assign wr_open = !perm_opt[req.slot] && !st_q.locked[req.slot];

	// Policy decision for the request against the state before it.
	always_comb begin
		ok = 1'b0;
		case (req.op)
			policy_pkg::OP_READ: begin
				ok = clear_readable(req.slot);
			end
			policy_pkg::OP_WRITE: begin
				case (req.slot)
					policy_pkg::SLOT_IOKEY:  ok = wr_open;
					policy_pkg::SLOT_DATA:   ok = wr_open;
					policy_pkg::SLOT_AES:    ok = 1'b1;
					policy_pkg::SLOT_CERT,
					policy_pkg::SLOT_SIGNER,
					policy_pkg::SLOT_SCERT:  ok = wr_open;
					policy_pkg::SLOT_PARENT: ok = wr_open;
					policy_pkg::SLOT_VALID:  ok = !st_q.validated;
					policy_pkg::SLOT_BOOTPK: ok = wr_open;
					default:                 ok = 1'b0;
				endcase
			end
			policy_pkg::OP_ENC_WRITE: begin
				// The payload is decrypted with the slot 6 key, so a nonce is needed.
				ok = (req.slot == policy_pkg::SLOT_SECRET) && wr_open && st_q.nonce;
			end
			policy_pkg::OP_COPY: begin
				ok = (req.slot >= policy_pkg::SLOT_CERT);
			end
			policy_pkg::OP_MAC_KEY: begin
				if (req.slot == policy_pkg::SLOT_BOOTDG) begin
					ok = 1'b0;
				end else if (req.slot == policy_pkg::SLOT_IOKEY) begin
					ok = st_q.nonce;
				end else begin
					ok = (req.slot >= policy_pkg::SLOT_SECRET);
				end
			end
			policy_pkg::OP_VERIFY: begin
				case (req.slot)
					policy_pkg::SLOT_VALID:  ok = st_q.validated;
					policy_pkg::SLOT_SIGNER,
					policy_pkg::SLOT_PARENT,
					policy_pkg::SLOT_BOOTPK: ok = 1'b1;
					default:                 ok = 1'b0;
				endcase
			end
			policy_pkg::OP_LOCK: begin
				ok = lockable(req.slot) && wr_open;
			end
			policy_pkg::OP_VALIDATE,
			policy_pkg::OP_INVALIDATE: begin
				ok = (req.slot == policy_pkg::SLOT_VALID);
			end
			policy_pkg::OP_NONCE_RAND,
			policy_pkg::OP_NONCE_ALT,
			policy_pkg::OP_SHA_INIT: begin
				ok = 1'b1;
			end
			policy_pkg::OP_KDF: begin
				ok = st_q.tk_valid;
			end
			policy_pkg::OP_SHA_UPDATE,
			policy_pkg::OP_SHA_FINAL,
			policy_pkg::OP_SHA_DIGEST: begin
				ok = (st_q.sha == policy_pkg::SHA_ACTIVE);
			end
			policy_pkg::OP_SIGN_DIG: begin
				ok = st_q.digest;
			end
			policy_pkg::OP_OTP_READ4,
			policy_pkg::OP_OTP_READ32: begin
				ok = 1'b1;
			end
			policy_pkg::OP_OTP_WRITE: begin
				ok = 1'b0;
			end
			policy_pkg::OP_SCRATCH_RD: begin
				ok = 1'b0;
			end
			default: begin
				ok = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state: side effects of an allowed request, then sleep on top.
	// Sleep wins over a same-cycle load so no stale scratch survives it.
	always_comb begin
		st_d = st_q;
		st_d.resp.valid = req.valid;
		if (req.valid) begin
			st_d.resp.allow  = ok;
			st_d.resp.status = ok ? policy_pkg::ST_OK : policy_pkg::ST_EXEC_ERR;
			st_d.resp.count  = policy_pkg::GROUP_LEN;
		end
		if (req.valid && ok) begin
			case (req.op)
				policy_pkg::OP_LOCK: begin
					st_d.locked[req.slot] = 1'b1;
				end
				policy_pkg::OP_VALIDATE: begin
					st_d.validated = 1'b1;
				end
				policy_pkg::OP_INVALIDATE: begin
					st_d.validated = 1'b0;
				end
				policy_pkg::OP_ENC_WRITE: begin
					st_d.nonce = 1'b0;
				end
				policy_pkg::OP_MAC_KEY: begin
					if (req.slot == policy_pkg::SLOT_IOKEY) begin
						st_d.nonce = 1'b0;
					end
				end
				policy_pkg::OP_NONCE_RAND: begin
					st_d.nonce    = 1'b1;
					st_d.tk_valid = 1'b1;
				end
				policy_pkg::OP_NONCE_ALT,
				policy_pkg::OP_KDF: begin
					st_d.altkey = 1'b1;
				end
				policy_pkg::OP_SHA_INIT: begin
					st_d.sha = policy_pkg::SHA_ACTIVE;
				end
				policy_pkg::OP_SHA_FINAL: begin
					st_d.sha      = policy_pkg::SHA_IDLE;
					st_d.tk_valid = 1'b1;
				end
				policy_pkg::OP_SHA_DIGEST: begin
					st_d.sha    = policy_pkg::SHA_IDLE;
					st_d.digest = 1'b1;
				end
				default: begin
				end
			endcase
		end
		if (sleep) begin
			st_d.nonce    = 1'b0;
			st_d.tk_valid = 1'b0;
			st_d.digest   = 1'b0;
			st_d.altkey   = 1'b0;
			st_d.sha      = policy_pkg::SHA_IDLE;
		end
	end

	// Locks and the validated flag stand for non-volatile state; sleep keeps them.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q           <= '0;
			st_q.locked    <= policy_pkg::LOCK_RST;
			st_q.validated <= policy_pkg::VALID_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// The one-time zone answers in the same cycle as the status group.
	otp_store #(
		.OTP_INIT (OTP_INIT)
	) u_otp (
		.clk   (clk),
		.reset (reset),
		.rd    (req.valid && (req.op == policy_pkg::OP_OTP_READ4 || req.op == policy_pkg::OP_OTP_READ32)),
		.wide  (req.op == policy_pkg::OP_OTP_READ32),
		.addr  (req.addr),
		.data  (otp_data)
	);

	assign resp      = st_q.resp;
	assign locked    = st_q.locked;
	assign validated = st_q.validated;
	assign nonce_ok  = st_q.nonce;

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	clear_slot5_a: assert property (
		req.valid && req.op == policy_pkg::OP_WRITE && req.slot == policy_pkg::SLOT_SECRET
		|=> resp.valid && !resp.allow && resp.status == policy_pkg::ST_EXEC_ERR)
		else $error("clear write to slot 5 was accepted");

	perm_slot5_a: assert property (
		req.valid && req.op == policy_pkg::OP_ENC_WRITE && perm_opt[5]
		|=> !resp.allow)
		else $error("encrypted write to permanent slot 5 accepted");

	copy_target_a: assert property (
		req.valid && req.op == policy_pkg::OP_COPY && req.slot >= 4'h5 && req.slot <= 4'h9
		|=> resp.valid && !resp.allow)
		else $error("copy into slots 5 to 9 accepted");

	nonce_need_a: assert property (
		req.valid && req.op == policy_pkg::OP_MAC_KEY && req.slot == policy_pkg::SLOT_IOKEY
		##0 !nonce_ok |=> !resp.allow)
		else $error("slot 6 key used without nonce");

	nonce_once_a: assert property (
		req.valid && req.op == policy_pkg::OP_ENC_WRITE ##1 resp.allow |-> !nonce_ok)
		else $error("nonce not consumed by slot 6 key use");

	perm_write_a: assert property (
		req.valid && req.op == policy_pkg::OP_WRITE && perm_opt[req.slot]
		&& req.slot != policy_pkg::SLOT_AES && req.slot != policy_pkg::SLOT_VALID
		|=> !resp.allow)
		else $error("write to permanently locked slot accepted");

	slot7_a: assert property (
		req.valid && req.slot == policy_pkg::SLOT_BOOTDG
		&& (req.op == policy_pkg::OP_READ || req.op == policy_pkg::OP_WRITE || req.op == policy_pkg::OP_MAC_KEY)
		|=> !resp.allow)
		else $error("slot 7 access accepted");

	slot9_a: assert property (
		req.valid && req.slot == policy_pkg::SLOT_AES
		&& (req.op == policy_pkg::OP_READ || req.op == policy_pkg::OP_WRITE)
		|=> resp.allow == $past(req.op == policy_pkg::OP_WRITE))
		else $error("slot 9 policy wrong");

	lock_hold_a: assert property (
		req.valid && req.op == policy_pkg::OP_LOCK ##1 resp.allow
		##1 req.valid && req.op == policy_pkg::OP_WRITE && req.slot == $past(req.slot, 2)
		|=> !resp.allow)
		else $error("write accepted after lock");

	verify14_a: assert property (
		req.valid && req.op == policy_pkg::OP_VERIFY && req.slot == policy_pkg::SLOT_VALID
		|=> resp.allow == $past(validated))
		else $error("slot 14 verify ignores validated state");

	otp_ro_a: assert property (
		req.valid && req.op == policy_pkg::OP_OTP_WRITE |=> resp.valid && !resp.allow)
		else $error("one-time zone write accepted");

	sleep_wipe_a: assert property (
		sleep |=> !nonce_ok && st_q.sha == policy_pkg::SHA_IDLE && !st_q.tk_valid && !st_q.digest
		&& !st_q.altkey)
		else $error("scratch state survived sleep");

	group_code_a: assert property (
		resp.valid |-> resp.count == policy_pkg::GROUP_LEN
		&& resp.status == (resp.allow ? policy_pkg::ST_OK : policy_pkg::ST_EXEC_ERR))
		else $error("response group malformed");

	sha_flow_a: assert property (
		req.valid && req.op == policy_pkg::OP_SHA_INIT && !sleep
		##1 !req.valid && !sleep
		##1 req.valid && req.op == policy_pkg::OP_SHA_UPDATE
		|=> resp.allow)
		else $error("update after initialize refused");
endmodule
`default_nettype wire

// File: host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host controller model: one request at a time, answer read just after the same edge that takes the request.
module host_model (
	input  wire logic              clk,
	input  wire policy_pkg::resp_s resp,
	output var  policy_pkg::req_s  req
);
	// The request lines idle low so nothing is taken before the first real command.
	initial begin
		req = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Raised just after an edge and held through the taking edge, so no edge sees a half-formed request.
	task automatic issue(input policy_pkg::op_e op, input logic [3:0] slot, input logic [3:0] addr,
		output policy_pkg::resp_s got);
		@(posedge clk);
		#1;
		req = '{valid: 1'b1, op: op, slot: slot, addr: addr};
		@(posedge clk);
		#1;
		req.valid = 1'b0;
		got = resp; // The answer pulse lasts one cycle, so it is read right here.
	endtask
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the slot policy block.
module tb_top;
	logic              clk;
	logic              reset;
	logic              sleep;
	logic [15:0]       perm_opt;
	policy_pkg::req_s  req;
	policy_pkg::resp_s resp;
	logic [255:0]      otp_data;
	logic [15:0]       locked;
	logic              validated;
	logic              nonce_ok;
	int                n_mismatch;
	int                samples_checked;

	// Arbitrary one-time zone contents; every byte differs so a wrong offset shows.
	function automatic logic [511:0] make_pat();
		logic [511:0] p;
		for (int i = 0; i < 64; i++) begin
			p[8*i +: 8] = 8'(3 * i + 1);
		end
		return p;
	endfunction
	localparam logic [511:0] OTP_PAT = make_pat();

	slot_access_policy_checker #(.OTP_INIT(OTP_PAT)) dut (
		.clk(clk), .reset(reset), .req(req), .perm_opt(perm_opt), .sleep(sleep), .resp(resp),
		.otp_data(otp_data), .locked(locked), .validated(validated), .nonce_ok(nonce_ok));
	host_model host (.clk(clk), .resp(resp), .req(req));

	////////////////////////////////////////////////////////////////////////////////
	// Free-running 10 MHz clock.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Watchdog sized well beyond the few hundred cycles the tests need.
	initial begin
		#(5000 * 100);
		n_mismatch++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Value compare; case inequality keeps unknowns from passing.
	task automatic check_val(input logic [255:0] got, input logic [255:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// Response compare: every answer is a four-byte group, refusals carry the execution error code.
	task automatic req_check(input policy_pkg::op_e op, input int slot, input int addr, input logic allow);
		policy_pkg::resp_s r;
		host.issue(op, 4'(slot), 4'(addr), r);
		check_val(256'(r.valid), 256'(1'b1));
		check_val(256'(r.allow), 256'(allow));
		check_val(256'(r.status), 256'(allow ? policy_pkg::ST_OK : policy_pkg::ST_EXEC_ERR));
		check_val(256'(r.count), 256'(policy_pkg::GROUP_LEN));
	endtask

	// Reset is held four cycles; options change only while it is held.
	task automatic do_reset(input logic [15:0] opt);
		reset = 1'b1;
		perm_opt = opt;
		repeat (4) @(posedge clk);
		#1;
		reset = 1'b0;
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		do_reset(16'h0000);
		check_val(256'(resp), 256'(0));
		check_val(otp_data, 256'(0));
		check_val(256'(locked), 256'(policy_pkg::LOCK_RST));
		check_val(256'(validated), 256'(policy_pkg::VALID_RST));
		check_val(256'(nonce_ok), 256'(0));
		$display("test reset done");
	endtask

	task automatic t_reads();
		for (int s = 5; s < 16; s++) begin
			req_check(policy_pkg::OP_READ, s, 0, s == 8 || s >= 10);
		end
		$display("test reads done");
	endtask

	// Lockable slots: write, lock, then the write is refused while slot 8 reads stay open.
	task automatic t_write_lock();
		int sl[7] = '{6, 8, 10, 11, 12, 13, 15};
		do_reset(16'h0000);
		foreach (sl[i]) begin
			req_check(policy_pkg::OP_WRITE, sl[i], 0, 1'b1);
			req_check(policy_pkg::OP_LOCK, sl[i], 0, 1'b1);
			check_val(256'(locked[sl[i]]), 256'(1'b1));
			req_check(policy_pkg::OP_WRITE, sl[i], 0, 1'b0);
			req_check(policy_pkg::OP_LOCK, sl[i], 0, 1'b0);
		end
		req_check(policy_pkg::OP_READ, 8, 0, 1'b1);
		req_check(policy_pkg::OP_WRITE, 9, 0, 1'b1);
		req_check(policy_pkg::OP_WRITE, 7, 0, 1'b0);
		req_check(policy_pkg::OP_WRITE, 5, 0, 1'b0);
		$display("test write and lock done");
	endtask

	// Permanent option: every write and lock refused, reads unchanged.
	task automatic t_perm();
		int sl[7] = '{6, 8, 10, 11, 12, 13, 15};
		do_reset(16'hFFE0);
		foreach (sl[i]) begin
			req_check(policy_pkg::OP_WRITE, sl[i], 0, 1'b0);
			req_check(policy_pkg::OP_LOCK, sl[i], 0, 1'b0);
			req_check(policy_pkg::OP_READ, sl[i], 0, sl[i] != 6);
		end
		req_check(policy_pkg::OP_NONCE_RAND, 0, 0, 1'b1);
		req_check(policy_pkg::OP_ENC_WRITE, 5, 0, 1'b0);
		$display("test permanent done");
	endtask

	// Each use of the slot 6 key spends the nonce, so every use needs a fresh nonce.
	task automatic t_nonce();
		do_reset(16'h0000);
		req_check(policy_pkg::OP_ENC_WRITE, 5, 0, 1'b0);
		req_check(policy_pkg::OP_NONCE_RAND, 0, 0, 1'b1);
		check_val(256'(nonce_ok), 256'(1'b1));
		req_check(policy_pkg::OP_ENC_WRITE, 5, 0, 1'b1);
		check_val(256'(nonce_ok), 256'(1'b0));
		req_check(policy_pkg::OP_MAC_KEY, 6, 0, 1'b0);
		req_check(policy_pkg::OP_NONCE_RAND, 0, 0, 1'b1);
		req_check(policy_pkg::OP_MAC_KEY, 6, 0, 1'b1);
		req_check(policy_pkg::OP_MAC_KEY, 7, 0, 1'b0);
		req_check(policy_pkg::OP_LOCK, 5, 0, 1'b1);
		req_check(policy_pkg::OP_NONCE_RAND, 0, 0, 1'b1);
		req_check(policy_pkg::OP_ENC_WRITE, 5, 0, 1'b0);
		for (int s = 5; s < 12; s++) begin
			req_check(policy_pkg::OP_COPY, s, 0, s >= 10);
		end
		$display("test nonce and copy done");
	endtask

	task automatic t_validate();
		req_check(policy_pkg::OP_VERIFY, 14, 0, 1'b0);
		req_check(policy_pkg::OP_WRITE, 14, 0, 1'b1);
		req_check(policy_pkg::OP_VALIDATE, 14, 0, 1'b1);
		check_val(256'(validated), 256'(1'b1));
		req_check(policy_pkg::OP_VERIFY, 14, 0, 1'b1);
		req_check(policy_pkg::OP_WRITE, 14, 0, 1'b0);
		req_check(policy_pkg::OP_READ, 14, 0, 1'b1);
		req_check(policy_pkg::OP_INVALIDATE, 14, 0, 1'b1);
		req_check(policy_pkg::OP_WRITE, 14, 0, 1'b1);
		req_check(policy_pkg::OP_VALIDATE, 13, 0, 1'b0);
		req_check(policy_pkg::OP_VERIFY, 11, 0, 1'b1);
		req_check(policy_pkg::OP_VERIFY, 8, 0, 1'b0);
		$display("test validation done");
	endtask

	// One-time zone: word and block reads at the edges of both blocks; a write changes nothing.
	task automatic t_otp();
		int ad[5] = '{0, 1, 7, 8, 15};
		foreach (ad[i]) begin
			req_check(policy_pkg::OP_OTP_READ4, 0, ad[i], 1'b1);
			check_val(otp_data, 256'(OTP_PAT[ad[i]*32 +: 32]));
		end
		req_check(policy_pkg::OP_OTP_READ32, 0, 8, 1'b1);
		check_val(otp_data, OTP_PAT[511:256]);
		req_check(policy_pkg::OP_OTP_READ32, 0, 15, 1'b1);
		check_val(otp_data, OTP_PAT[511:256]);
		req_check(policy_pkg::OP_OTP_WRITE, 0, 0, 1'b0);
		req_check(policy_pkg::OP_OTP_READ32, 0, 7, 1'b1);
		check_val(otp_data, OTP_PAT[255:0]);
		$display("test one-time zone done");
	endtask

	// Scratch buffers: hash phases, digest feed, key derivation, then sleep wipes them.
	task automatic t_scratch();
		do_reset(16'h0000);
		req_check(policy_pkg::OP_SCRATCH_RD, 0, 0, 1'b0);
		req_check(policy_pkg::OP_SHA_UPDATE, 0, 0, 1'b0);
		req_check(policy_pkg::OP_KDF, 0, 0, 1'b0);
		req_check(policy_pkg::OP_SHA_INIT, 0, 0, 1'b1);
		repeat (3) req_check(policy_pkg::OP_SHA_UPDATE, 0, 0, 1'b1);
		req_check(policy_pkg::OP_SHA_FINAL, 0, 0, 1'b1);
		req_check(policy_pkg::OP_SHA_FINAL, 0, 0, 1'b0);
		req_check(policy_pkg::OP_SIGN_DIG, 0, 0, 1'b0);
		req_check(policy_pkg::OP_KDF, 0, 0, 1'b1);
		req_check(policy_pkg::OP_SHA_INIT, 0, 0, 1'b1);
		req_check(policy_pkg::OP_SHA_DIGEST, 0, 0, 1'b1);
		req_check(policy_pkg::OP_SIGN_DIG, 0, 0, 1'b1);
		req_check(policy_pkg::OP_NONCE_RAND, 0, 0, 1'b1);
		req_check(policy_pkg::OP_SHA_INIT, 0, 0, 1'b1);
		req_check(policy_pkg::OP_LOCK, 8, 0, 1'b1);
		@(posedge clk);
		#1;
		sleep = 1'b1;
		@(posedge clk);
		#1;
		sleep = 1'b0;
		check_val(256'(nonce_ok), 256'(1'b0));
		check_val(256'(locked[8]), 256'(1'b1));
		req_check(policy_pkg::OP_SIGN_DIG, 0, 0, 1'b0);
		req_check(policy_pkg::OP_KDF, 0, 0, 1'b0);
		req_check(policy_pkg::OP_SHA_UPDATE, 0, 0, 1'b0);
		req_check(policy_pkg::OP_NONCE_ALT, 0, 0, 1'b1);
		$display("test scratch done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence; every input has a value at time zero.
	initial begin
		reset = 1'b1;
		sleep = 1'b0;
		perm_opt = 16'h0000;
		n_mismatch = 0;
		samples_checked = 0;
		t_reset();
		t_reads();
		t_write_lock();
		t_perm();
		t_nonce();
		t_validate();
		t_otp();
		t_scratch();
		report_and_stop();
	end
endmodule
`default_nettype wire
